// ==== rtl/tscfg_top.sv ====
// Purpose: Two-wire slave holding the settings register and the measurement sequencer
// Assumes: scl and sda come from pins; conv_done and ext_rd_data come from logic on ref_clk
// Notes: Reads of other pointers return ext_rd_data; writes to them are refused
`include "tscfg_regs.svh"
`default_nettype none

module tscfg_top import tscfg_pkg::*; #(
  parameter int TMR_W = 25,
  parameter int CONV_9B_CYC = `TSC_CONV9_MS * `TSC_CYC_PER_MS,
  parameter int CONV_10B_CYC = `TSC_CONV10_MS * `TSC_CYC_PER_MS,
  parameter int CONV_11B_CYC = `TSC_CONV11_MS * `TSC_CYC_PER_MS,
  parameter int CONV_12B_CYC = `TSC_CONV12_MS * `TSC_CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] strap_address_bits,
  // Other registers of the device
  input wire logic [15:0] ext_rd_data,
  // Conversion engine
  input wire logic conv_done,
  output logic conv_start,
  output logic conv_active,
  output logic sample_store,
  output logic in_shutdown,
  // Settings fields
  output logic [1:0] resolution_select,
  output logic [1:0] fault_queue_depth,
  output logic alarm_polarity,
  output logic alarm_mode_select,
  output logic shutdown_request
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ****************************************
  // Read data selection
  // ****************************************
  logic [6:0] cfg_reg, cfg_next;
  logic [7:0] ptr_reg, ptr_next;

  // Bit 15 is never stored, so it reads zero by construction
  function automatic logic [7:0] rd_byte(input logic hi);
    if (ptr_reg == `TSC_PTR_CFG)
      rd_byte = hi ? {1'b0, cfg_reg} : `TSC_RSV_BYTE;
    else
      rd_byte = hi ? ext_rd_data[15:8] : ext_rd_data[7:0];
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  tscfg_bus_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, ob_reg, ob_next;
  logic drv_reg, drv_next, rw_reg, rw_next, first_reg, first_next;
  logic mack_reg, mack_next, hi_reg, hi_next, cfg_commit;
  logic addr_hit;
  assign addr_hit = (sh_reg[7:1] == {`TSC_ADDR_HI, strap_address_bits});

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ob_next = ob_reg;
    drv_next = drv_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    mack_next = mack_reg;
    hi_next = hi_reg;
    ptr_next = ptr_reg;
    cfg_next = cfg_reg;
    cfg_commit = 1'b0;
    if (start_ev) begin
      // Half-received byte is simply dropped
      st_next = TSC_ST_ADDR;
      cnt_next = 4'h0;
      drv_next = 1'b0;
    end else if (stop_ev) begin
      st_next = TSC_ST_IDLE;
      drv_next = 1'b0;
    end else begin
      if (scl_rise && st_reg != TSC_ST_IDLE) begin
        sh_next = {sh_reg[6:0], sda_s2};
        cnt_next = cnt_reg + 4'h1;
        if (st_reg == TSC_ST_RACK)
          mack_next = ~sda_s2;
      end
      if (scl_fall) begin
        unique case (st_reg)
          TSC_ST_IDLE: begin
          end
          TSC_ST_ADDR: begin
            if (cnt_reg == 4'h8) begin
              cnt_next = 4'h0;
              if (addr_hit) begin
                rw_next = sh_reg[0];
                drv_next = 1'b1;
                st_next = TSC_ST_ACK_ADDR;
              end else begin
                st_next = TSC_ST_IDLE;
              end
            end
          end
          TSC_ST_ACK_ADDR: begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              ob_next = rd_byte(1'b1);
              drv_next = ~ob_next[7];
              hi_next = 1'b0;
              st_next = TSC_ST_RDATA;
            end else begin
              drv_next = 1'b0;
              st_next = TSC_ST_PTR;
            end
          end
          TSC_ST_PTR: begin
            if (cnt_reg == 4'h8) begin
              cnt_next = 4'h0;
              ptr_next = sh_reg;
              drv_next = 1'b1;
              st_next = TSC_ST_ACK_PTR;
            end
          end
          TSC_ST_ACK_PTR: begin
            drv_next = 1'b0;
            cnt_next = 4'h0;
            first_next = 1'b1;
            st_next = TSC_ST_WDATA;
          end
          TSC_ST_WDATA: begin
            if (cnt_reg == 4'h8) begin
              cnt_next = 4'h0;
              first_next = 1'b0;
              if (ptr_reg == `TSC_PTR_CFG) begin
                // Later bytes are acked but dropped
                cfg_commit = first_reg;
                if (first_reg)
                  cfg_next = sh_reg[6:0];
                drv_next = 1'b1;
                st_next = TSC_ST_ACK_WDATA;
              end else begin
                st_next = TSC_ST_IDLE;
              end
            end
          end
          TSC_ST_ACK_WDATA: begin
            drv_next = 1'b0;
            cnt_next = 4'h0;
            st_next = TSC_ST_WDATA;
          end
          TSC_ST_RDATA: begin
            if (cnt_reg == 4'h8) begin
              cnt_next = 4'h0;
              drv_next = 1'b0;
              st_next = TSC_ST_RACK;
            end else begin
              ob_next = {ob_reg[6:0], 1'b0};
              drv_next = ~ob_reg[6];
            end
          end
          TSC_ST_RACK: begin
            // Ack clock already bumped the count; next byte needs all eight
            cnt_next = 4'h0;
            if (mack_reg) begin
              ob_next = rd_byte(hi_reg);
              drv_next = ~ob_next[7];
              hi_next = ~hi_reg;
              st_next = TSC_ST_RDATA;
            end else begin
              drv_next = 1'b0;
              st_next = TSC_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= TSC_ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ob_reg <= 8'h00;
      drv_reg <= 1'b0;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      mack_reg <= 1'b0;
      hi_reg <= 1'b1;
      ptr_reg <= `TSC_PTR_RST;
      cfg_reg <= `TSC_CFG_RST;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ob_reg <= ob_next;
      drv_reg <= drv_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      mack_reg <= mack_next;
      hi_reg <= hi_next;
      ptr_reg <= ptr_next;
      cfg_reg <= cfg_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = drv_reg;

  // ****************************************
  // Settings fields
  // ****************************************
  assign resolution_select = cfg_reg[`TSC_B_RES +: 2];
  assign fault_queue_depth = cfg_reg[`TSC_B_FQ +: 2];
  assign alarm_polarity = cfg_reg[`TSC_B_POL];
  assign alarm_mode_select = cfg_reg[`TSC_B_MODE];
  assign shutdown_request = cfg_reg[`TSC_B_SD];

  // ****************************************
  // Measurement sequencer
  // ****************************************
  function automatic logic [TMR_W-1:0] conv_limit(input logic [1:0] res);
    unique case (res)
      2'h0: conv_limit = TMR_W'(CONV_9B_CYC);
      2'h1: conv_limit = TMR_W'(CONV_10B_CYC);
      2'h2: conv_limit = TMR_W'(CONV_11B_CYC);
      2'h3: conv_limit = TMR_W'(CONV_12B_CYC);
    endcase
  endfunction

  tscfg_seq_e sq_reg, sq_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic pend_reg, pend_next, start_reg, start_next, store_reg, store_next;
  logic end_conv;
  // Engine that never answers is cut off at the conversion time of the selected resolution
  assign end_conv = (sq_reg == TSC_SQ_CONV) &&
    (conv_done || tmr_reg >= conv_limit(resolution_select));

  always_comb begin
    sq_next = sq_reg;
    tmr_next = tmr_reg;
    pend_next = pend_reg;
    start_next = 1'b0;
    store_next = 1'b0;
    unique case (sq_reg)
      TSC_SQ_SHUT: begin
        if (!shutdown_request || pend_reg) begin
          sq_next = TSC_SQ_CONV;
          tmr_next = '0;
          start_next = 1'b1;
        end
      end
      TSC_SQ_CONV: begin
        if (end_conv) begin
          store_next = 1'b1;
          tmr_next = '0;
          if (shutdown_request) begin
            sq_next = TSC_SQ_SHUT;
            pend_next = 1'b0;
          end else begin
            start_next = 1'b1;
          end
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
    endcase
    // Set only while shut, so a trigger written during a conversion is dropped
    if (cfg_commit && sh_reg[`TSC_B_OS] && sq_reg == TSC_SQ_SHUT)
      pend_next = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Starts shut for one cycle, then leaves since the shutdown bit is clear
      sq_reg <= TSC_SQ_SHUT;
      tmr_reg <= '0;
      pend_reg <= 1'b0;
      start_reg <= 1'b0;
      store_reg <= 1'b0;
    end else begin
      sq_reg <= sq_next;
      tmr_reg <= tmr_next;
      pend_reg <= pend_next;
      start_reg <= start_next;
      store_reg <= store_next;
    end
  end

  assign conv_start = start_reg;
  assign sample_store = store_reg;
  assign conv_active = (sq_reg == TSC_SQ_CONV);
  assign in_shutdown = (sq_reg == TSC_SQ_SHUT);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_reset_clears_regs: assert property ($fell(rst) |-> cfg_reg == 7'h00 && ptr_reg == 8'h00)
    else $error("settings or pointer not cleared by reset");
  a_os_reads_zero: assert property ((st_reg == TSC_ST_ACK_ADDR && scl_fall && rw_reg &&
    ptr_reg == 8'h01 && !start_ev && !stop_ev) |=> !ob_reg[7])
    else $error("one-shot bit read back as one");
  a_low_byte_zero: assert property ((st_reg == TSC_ST_RACK && scl_fall && mack_reg && !hi_reg &&
    ptr_reg == 8'h01 && !start_ev && !stop_ev) |=> ob_reg == 8'h00)
    else $error("reserved byte not zero");
  a_os_ignored_run: assert property ((cfg_commit && sq_reg == TSC_SQ_CONV && !pend_reg) |=> !pend_reg)
    else $error("one-shot taken while running");
  a_oneshot_returns: assert property ((end_conv && shutdown_request) |=> in_shutdown && !pend_reg &&
    sample_store)
    else $error("one-shot did not return to shutdown");
  a_conv_not_cut: assert property ((conv_active && !end_conv) |=> conv_active && !sample_store)
    else $error("conversion aborted early");
  a_resume_run: assert property ((in_shutdown && !shutdown_request) |=> conv_active ##0 conv_start)
    else $error("did not resume after shutdown clear");
  a_conv_bounded: assert property ((conv_active && tmr_reg >= conv_limit(resolution_select)) |=> sample_store)
    else $error("conversion ran past its limit");
  a_back_to_back: assert property ((end_conv && !shutdown_request) |=> conv_start ##1 !conv_start)
    else $error("continuous conversion not restarted");
  a_partial_kept: assert property ((start_ev || stop_ev) |=> cfg_reg == $past(cfg_reg))
    else $error("settings changed by partial byte");
  a_extra_dropped: assert property ((st_reg == TSC_ST_WDATA && !first_reg) |=> $stable(cfg_reg))
    else $error("later data byte changed settings");
  a_addr_acked: assert property ((st_reg == TSC_ST_ADDR && scl_fall && cnt_reg == 4'h8 && addr_hit &&
    !start_ev && !stop_ev) |=> sda_oe)
    else $error("matching address not acked");
  a_nack_release: assert property ((st_reg == TSC_ST_RACK && scl_fall && !mack_reg && !start_ev &&
    !stop_ev) |=> !sda_oe && st_reg == TSC_ST_IDLE)
    else $error("line held after master nack");

  c_cfg_write: cover property (cfg_commit);
  c_cfg_read: cover property (st_reg == TSC_ST_RDATA && ptr_reg == 8'h01);
  c_oneshot: cover property (in_shutdown && pend_reg ##1 conv_start);
  c_enter_shut: cover property (conv_active ##1 in_shutdown);

endmodule
`default_nettype wire

// ==== rtl/tscfg_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing of the settings register
// Assumes: Included by the settings block and its package users
// Notes: Field positions count within the upper (settings) byte
`ifndef TSCFG_REGS_SVH
`define TSCFG_REGS_SVH

// ****************************************
// Pointer values
// ****************************************
`define TSC_PTR_TEMP 8'h00
`define TSC_PTR_CFG 8'h01
`define TSC_PTR_RST 8'h00

// ****************************************
// Bus address and settings layout
// ****************************************
`define TSC_ADDR_HI 4'h9
`define TSC_CFG_RST 7'h00
`define TSC_RSV_BYTE 8'h00
`define TSC_B_OS 7
`define TSC_B_RES 5
`define TSC_B_FQ 3
`define TSC_B_POL 2
`define TSC_B_MODE 1
`define TSC_B_SD 0

// ****************************************
// Timing
// ****************************************
`define TSC_CLK_MHZ 125
`define TSC_CYC_PER_MS (`TSC_CLK_MHZ * 1000)
`define TSC_CONV9_MS 25
`define TSC_CONV10_MS 50
`define TSC_CONV11_MS 100
`define TSC_CONV12_MS 200

`endif

// ==== rtl/tscfg_pkg.sv ====
// Purpose: Types shared by the settings register block
// Assumes: Nothing beyond the standard language
// Notes: Constants live in tscfg_regs.svh
`default_nettype none
package tscfg_pkg;
  typedef enum logic [3:0] {
    TSC_ST_IDLE = 4'h0,
    TSC_ST_ADDR = 4'h1,
    TSC_ST_ACK_ADDR = 4'h2,
    TSC_ST_PTR = 4'h3,
    TSC_ST_ACK_PTR = 4'h4,
    TSC_ST_WDATA = 4'h5,
    TSC_ST_ACK_WDATA = 4'h6,
    TSC_ST_RDATA = 4'h7,
    TSC_ST_RACK = 4'h8
  } tscfg_bus_e;
  typedef enum logic {
    TSC_SQ_SHUT = 1'b0,
    TSC_SQ_CONV = 1'b1
  } tscfg_seq_e;
endpackage
`default_nettype wire

// ==== verification/tscfg_bus_master.sv ====
// Purpose: Behavioural two-wire bus master facing the settings block
// Assumes: Open-drain data line with pull-up, scl driven by this master only
// Notes: Q cycles per quarter bit; scl stands high while idle
`default_nettype none
module tscfg_bus_master #(
  parameter int Q = 8
) (
  // Clock
  input wire logic ref_clk,
  // Bus lines
  input wire logic sda_line,
  output var logic scl,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ****************************************
  // Bus phases
  // ****************************************
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Also a repeated start when scl is low
  task automatic start();
    sda_low <= 1'b0;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_low <= 1'b1;
    hold(Q);
    scl <= 1'b0;
    hold(Q);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_low <= 1'b0;
    hold(2 * Q);
  endtask

  // Data set mid-low, sampled mid-high, well clear of slave turnaround
  task automatic bit_io(input logic b, output logic seen);
    sda_low <= ~b;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    seen = sda_line;
    hold(Q);
    scl <= 1'b0;
    hold(Q);
  endtask

  // Fewer than 8 bits leaves a partial byte, no ack clock
  task automatic send_bits(input logic [7:0] d, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(d[i], s);
    end
    if (n == 8) begin
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the settings register block
// Assumes: Bus master model in tscfg_bus_master.sv
// Notes: Conversion limits shortened to 40/80/160/320 cycles
`include "tscfg_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM [4] = '{40, 80, 160, 320};
  localparam logic [2:0] STRAP = 3'h5;
  logic ref_clk, rst, conv_done, done_en, prev_shut, a, scl, sda_low;
  logic sda_out, sda_oe, conv_start, conv_active, sample_store, in_shutdown;
  logic alarm_polarity, alarm_mode_select, shutdown_request;
  logic [1:0] resolution_select, fault_queue_depth;
  logic [15:0] ext_rd_data;
  logic [7:0] hi, lo, c;
  logic [6:0] fields;
  wire sda_line;
  int fails, cmp_count, dcnt, cyc, last, gap, n_start, snap;

  assign sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
  assign fields = {resolution_select, fault_queue_depth, alarm_polarity, alarm_mode_select, shutdown_request};

  tscfg_top #(.CONV_9B_CYC(40), .CONV_10B_CYC(80), .CONV_11B_CYC(160), .CONV_12B_CYC(320)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_address_bits(STRAP), .ext_rd_data(ext_rd_data), .conv_done(conv_done), .conv_start(conv_start),
    .conv_active(conv_active), .sample_store(sample_store), .in_shutdown(in_shutdown),
    .resolution_select(resolution_select), .fault_queue_depth(fault_queue_depth),
    .alarm_polarity(alarm_polarity), .alarm_mode_select(alarm_mode_select), .shutdown_request(shutdown_request));
  tscfg_bus_master u_mst (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Checking and reporting
  // ****************************************
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Engine stand-in: done after 20 cycles unless held off to force timeouts
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    conv_done <= 1'b0;
    prev_shut <= in_shutdown;
    if (conv_start) begin
      dcnt <= 20;
      n_start <= n_start + 1;
      gap <= cyc - last;
      last <= cyc;
    end else if (dcnt > 0) begin
      dcnt <= dcnt - 1;
      conv_done <= (dcnt == 1) && done_en;
    end
    if (!rst && in_shutdown && !prev_shut) chk("store with shutdown", sample_store, 1'b1);
  end

  // ****************************************
  // Bus transfers
  // ****************************************
  task automatic bus_write(input logic [7:0] ptr, d0, d1, input int nd);
    logic k;
    u_mst.start();
    u_mst.send_bits({`TSC_ADDR_HI, STRAP, 1'b0}, 8, k);
    chk("address ack", k, 1'b1);
    u_mst.send_bits(ptr, 8, k);
    chk("pointer ack", k, 1'b1);
    if (nd > 0) begin
      u_mst.send_bits(d0, 8, k);
      chk("data ack", k, 1'b1);
    end
    if (nd > 1) begin
      u_mst.send_bits(d1, 8, k);
      chk("extra byte ack", k, 1'b1);
    end
    u_mst.stop();
  endtask

  task automatic bus_read(output logic [7:0] h, l);
    logic k;
    u_mst.start();
    u_mst.send_bits({`TSC_ADDR_HI, STRAP, 1'b1}, 8, k);
    chk("read address ack", k, 1'b1);
    u_mst.recv_byte(1'b1, h);
    u_mst.recv_byte(1'b0, l);
    chk("release after nack", sda_oe, 1'b0);
    u_mst.stop();
  endtask

  task automatic expect_cfg(input logic [7:0] b);
    bus_read(hi, lo);
    chk("settings byte", hi, {1'b0, b[6:0]});
    chk("reserved byte", lo, `TSC_RSV_BYTE);
    chk("field outputs", fields, b[6:0]);
  endtask

  task automatic wait_shut(input logic v);
    int n;
    n = 0;
    while (in_shutdown !== v && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("shutdown state", in_shutdown, v);
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    done_en = 1'b1;
    ext_rd_data = 16'hA5C3;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("reset fields", fields, 7'h00);
    bus_read(hi, lo);
    chk("pointer reset read", {hi, lo}, 16'hA5C3);
    bus_write(`TSC_PTR_CFG, 8'h00, 8'h00, 0);
    expect_cfg(`TSC_CFG_RST);
    u_mst.start();
    u_mst.send_bits({`TSC_ADDR_HI, ~STRAP, 1'b0}, 8, a);
    chk("foreign address", a, 1'b0);
    u_mst.stop();
    // Every field code but shutdown, one-shot set while running must be dropped
    for (int i = 0; i < 4; i++) begin
      c = {1'b1, i[1:0], ~i[1:0], i[0], i[1], 1'b0};
      bus_write(`TSC_PTR_CFG, c, 8'h00, 1);
      expect_cfg(c);
      chk("stays running", in_shutdown, 1'b0);
    end
    bus_write(`TSC_PTR_CFG, 8'h42, 8'h3C, 2);
    expect_cfg(8'h42);
    // Partial byte cut by stop, then by repeated start
    for (int k = 0; k < 2; k++) begin
      u_mst.start();
      u_mst.send_bits({`TSC_ADDR_HI, STRAP, 1'b0}, 8, a);
      u_mst.send_bits(`TSC_PTR_CFG, 8, a);
      u_mst.send_bits(8'h3C, 5, a);
      if (k == 0) u_mst.stop();
      expect_cfg(8'h42);
    end
    // Engine never answers: each conversion ends on its limit
    done_en <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      c = {1'b0, r[1:0], 5'h00};
      bus_write(`TSC_PTR_CFG, c, 8'h00, 1);
      repeat (1000) @(posedge ref_clk);
      chk("conversion limit", (gap >= LIM[r]) && (gap <= LIM[r] + 2), 1'b1);
    end
    done_en <= 1'b1;
    bus_write(`TSC_PTR_CFG, 8'h61, 8'h00, 1);
    wait_shut(1'b1);
    snap = n_start;
    repeat (700) @(posedge ref_clk);
    chk("idle in shutdown", n_start - snap, 0);
    chk("no conversion in shutdown", conv_active, 1'b0);
    snap = n_start;
    bus_write(`TSC_PTR_CFG, 8'hE1, 8'h00, 1);
    wait_shut(1'b1);
    chk("one-shot count", n_start - snap, 1);
    expect_cfg(8'h61);
    bus_write(`TSC_PTR_CFG, 8'h00, 8'h00, 1);
    wait_shut(1'b0);
    snap = n_start;
    repeat (200) @(posedge ref_clk);
    chk("running again", n_start - snap > 3, 1'b1);
    chk("conversion active", conv_active, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
